// [logic/status_pin_defines.vh]
// Purpose: constants for the two status pin function selectors
// Assumes: 200 MHz clock, plain register port with one-cycle read latency
// Notes: definitions only
`ifndef STATUS_PIN_DEFINES_VH
`define STATUS_PIN_DEFINES_VH

// ==========================================
// register offsets (byte addresses)
`define REG_PIN2_CFG 8'h00
`define REG_PIN3_CFG 8'h04
`define REG_PIN2_PWM_PERIOD 8'h08
`define REG_PIN2_PWM_HIGH 8'h0C
`define REG_PIN3_PWM_PERIOD 8'h10
`define REG_PIN3_PWM_HIGH 8'h14
`define REG_PIN_STATUS 8'h18

// ==========================================
// configuration fields
`define CFG_FUNC_LSB 0
`define CFG_FUNC_MSB 1
`define CFG_INVERT_BIT 2
`define CFG_OUTSEL_LSB 4
`define CFG_OUTSEL_MSB 5
`define CFG_RESET_VALUE 32'h00000000

// pin function codes
`define FUNC_STATUS 2'h0
`define FUNC_INPUT 2'h1
`define FUNC_OUTPUT 2'h2

// general output selections
`define OUT_TRUE 2'h0
`define OUT_FALSE 2'h1
`define OUT_PWM 2'h2

// pwm counters
`define PWM_WIDTH 32
`define PWM_PERIOD_RESET 32'h00000000
`define PWM_HIGH_RESET 32'h00000000
`define PWM_ONE 32'h00000001

// idle and reset levels
`define READ_IDLE 32'h00000000
`define PIN_RESET_LEVEL 1'b1
`define OE_DRIVE_N 1'b0

`endif

// [logic/pwm_gen.v]
// Purpose: one pwm waveform generator
// Assumes: period and high time given in clock cycles
// Notes: period of zero holds the output low
`timescale 1ns/1ps
`include "status_pin_defines.vh"

module pwm_gen (
   clk,
   rst_n,
   enable,
   period,
   high_time,
   pwm_out
);
   input wire clk;
   input wire rst_n;
   input wire enable;
   input wire [`PWM_WIDTH-1:0] period;
   input wire [`PWM_WIDTH-1:0] high_time;
   output reg pwm_out;

   reg [`PWM_WIDTH-1:0] count_r;
   reg [`PWM_WIDTH-1:0] count_nxt;

   // ==========================================
   // period counter
   always @* begin
      count_nxt = count_r + `PWM_ONE;
      // counter restarts if the period is shortened below it
      if (!enable || period == `PWM_PERIOD_RESET || count_nxt >= period) begin
         count_nxt = `PWM_PERIOD_RESET;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= `PWM_PERIOD_RESET;
         pwm_out <= 1'b0;
      end else begin
         count_r <= count_nxt;
         pwm_out <= enable && (count_nxt < high_time) && (period != `PWM_PERIOD_RESET); // [RQ8]
      end
   end
endmodule

// [logic/status_pin_function_select.v]
// Purpose: function select, polarity and drive for the second and third status pins
// Assumes: pin inputs synchronous to clk; software uses the plain register port
// Notes: output enable is active low; pwm period and high time are in clock cycles
// Behaviour
// [RQ1] pin2: protection, input or output; protection default
// [RQ2] pin3: off indicator, input or output; indicator default
// [RQ3] pin2 high unless protection active
// [RQ4] pin3 high while main output off
// [RQ5] invert flips status level in every state
// [RQ6] input function releases pin, samples level
// [RQ7] general output drives true, false or pwm
// [RQ8] pwm frequency and duty separately programmable
// [RQ9] true drives low, false drives high
// [RQ10] invert swaps the active pin level
// [RQ11] status pins track state with no software
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "status_pin_defines.vh"

module status_pin_function_select (
   clk,
   rst_n,
   protection_active,
   main_output_on,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   pin2_in,
   pin2_out,
   pin2_oe_n,
   pin3_in,
   pin3_out,
   pin3_oe_n
);
   input wire clk;
   input wire rst_n;
   input wire protection_active;
   input wire main_output_on;
   input wire [7:0] reg_addr;
   input wire [31:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [31:0] reg_rdata;
   input wire pin2_in;
   output reg pin2_out;
   output reg pin2_oe_n;
   input wire pin3_in;
   output reg pin3_out;
   output reg pin3_oe_n;

   reg [31:0] cfg2_r;
   reg [31:0] cfg3_r;
   reg [`PWM_WIDTH-1:0] per2_r;
   reg [`PWM_WIDTH-1:0] hi2_r;
   reg [`PWM_WIDTH-1:0] per3_r;
   reg [`PWM_WIDTH-1:0] hi3_r;
   reg in2_r;
   reg in3_r;
   reg [31:0] rdata_nxt;
   reg pin2_nxt;
   reg pin3_nxt;
   wire [1:0] func2;
   wire [1:0] func3;
   wire [1:0] sel2;
   wire [1:0] sel3;
   wire inv2;
   wire inv3;
   wire pwm2;
   wire pwm3;
   wire pwm2_en;
   wire pwm3_en;

   assign func2 = cfg2_r[`CFG_FUNC_MSB:`CFG_FUNC_LSB];
   assign func3 = cfg3_r[`CFG_FUNC_MSB:`CFG_FUNC_LSB];
   assign sel2 = cfg2_r[`CFG_OUTSEL_MSB:`CFG_OUTSEL_LSB];
   assign sel3 = cfg3_r[`CFG_OUTSEL_MSB:`CFG_OUTSEL_LSB];
   assign inv2 = cfg2_r[`CFG_INVERT_BIT];
   assign inv3 = cfg3_r[`CFG_INVERT_BIT];
   assign pwm2_en = (func2 == `FUNC_OUTPUT) && (sel2 == `OUT_PWM);
   assign pwm3_en = (func3 == `FUNC_OUTPUT) && (sel3 == `OUT_PWM);

   // ==========================================
   // register write
   // config fields are masked to their width so reserved bits read zero
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg2_r <= `CFG_RESET_VALUE; // [RQ1]
         cfg3_r <= `CFG_RESET_VALUE; // [RQ2]
         per2_r <= `PWM_PERIOD_RESET;
         hi2_r <= `PWM_HIGH_RESET;
         per3_r <= `PWM_PERIOD_RESET;
         hi3_r <= `PWM_HIGH_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_PIN2_CFG: begin
               cfg2_r <= {26'h0, reg_wdata[`CFG_OUTSEL_MSB:`CFG_OUTSEL_LSB], 1'b0,
                          reg_wdata[`CFG_INVERT_BIT], reg_wdata[`CFG_FUNC_MSB:`CFG_FUNC_LSB]};
            end
            `REG_PIN3_CFG: begin
               cfg3_r <= {26'h0, reg_wdata[`CFG_OUTSEL_MSB:`CFG_OUTSEL_LSB], 1'b0,
                          reg_wdata[`CFG_INVERT_BIT], reg_wdata[`CFG_FUNC_MSB:`CFG_FUNC_LSB]};
            end
            `REG_PIN2_PWM_PERIOD: begin
               per2_r <= reg_wdata; // [RQ8]
            end
            `REG_PIN2_PWM_HIGH: begin
               hi2_r <= reg_wdata; // [RQ8]
            end
            `REG_PIN3_PWM_PERIOD: begin
               per3_r <= reg_wdata;
            end
            `REG_PIN3_PWM_HIGH: begin
               hi3_r <= reg_wdata;
            end
            default: begin
               cfg2_r <= cfg2_r;
            end
         endcase
      end
   end

   // ==========================================
   // register read, one cycle latency, unmapped reads zero
   always @* begin
      rdata_nxt = `READ_IDLE;
      case (reg_addr)
         `REG_PIN2_CFG: rdata_nxt = cfg2_r;
         `REG_PIN3_CFG: rdata_nxt = cfg3_r;
         `REG_PIN2_PWM_PERIOD: rdata_nxt = per2_r;
         `REG_PIN2_PWM_HIGH: rdata_nxt = hi2_r;
         `REG_PIN3_PWM_PERIOD: rdata_nxt = per3_r;
         `REG_PIN3_PWM_HIGH: rdata_nxt = hi3_r;
         `REG_PIN_STATUS: rdata_nxt = {28'h0, pin3_out, pin2_out, in3_r, in2_r};
         default: rdata_nxt = `READ_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `READ_IDLE;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= `READ_IDLE;
      end
   end

   // ==========================================
   // pwm generators
   pwm_gen u_pwm2 (
      .clk(clk),
      .rst_n(rst_n),
      .enable(pwm2_en),
      .period(per2_r),
      .high_time(hi2_r),
      .pwm_out(pwm2)
   );

   pwm_gen u_pwm3 (
      .clk(clk),
      .rst_n(rst_n),
      .enable(pwm3_en),
      .period(per3_r),
      .high_time(hi3_r),
      .pwm_out(pwm3)
   );

   // ==========================================
   // pin level select
   // status functions depend only on live inputs and the invert bit, so no software step is needed
   always @* begin
      case (func2)
         `FUNC_STATUS: pin2_nxt = (~protection_active) ^ inv2; // [RQ3] [RQ5] [RQ11]
         `FUNC_OUTPUT: begin
            case (sel2) // [RQ7]
               `OUT_TRUE: pin2_nxt = inv2; // [RQ9] [RQ10]
               `OUT_FALSE: pin2_nxt = ~inv2; // [RQ9] [RQ10]
               `OUT_PWM: pin2_nxt = pwm2 ^ inv2; // [RQ10]
               default: pin2_nxt = ~inv2;
            endcase
         end
         default: pin2_nxt = 1'b0;
      endcase
      case (func3)
         `FUNC_STATUS: pin3_nxt = (~main_output_on) ^ inv3; // [RQ4] [RQ5] [RQ11]
         `FUNC_OUTPUT: begin
            case (sel3) // [RQ7]
               `OUT_TRUE: pin3_nxt = inv3; // [RQ9] [RQ10]
               `OUT_FALSE: pin3_nxt = ~inv3; // [RQ9] [RQ10]
               `OUT_PWM: pin3_nxt = pwm3 ^ inv3; // [RQ10]
               default: pin3_nxt = ~inv3;
            endcase
         end
         default: pin3_nxt = 1'b0;
      endcase
   end

   // ==========================================
   // pin drive and input sampling
   // reset drives the inactive status level: no protection, output off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin2_out <= `PIN_RESET_LEVEL;
         pin3_out <= `PIN_RESET_LEVEL;
         pin2_oe_n <= `OE_DRIVE_N;
         pin3_oe_n <= `OE_DRIVE_N;
         in2_r <= 1'b0;
         in3_r <= 1'b0;
      end else begin
         pin2_out <= pin2_nxt;
         pin3_out <= pin3_nxt;
         pin2_oe_n <= (func2 == `FUNC_INPUT) || (func2 > `FUNC_OUTPUT); // [RQ6]
         pin3_oe_n <= (func3 == `FUNC_INPUT) || (func3 > `FUNC_OUTPUT); // [RQ6]
         // inverted input reports the swapped active level
         in2_r <= pin2_in ^ inv2; // [RQ6] [RQ10]
         in3_r <= pin3_in ^ inv3; // [RQ6] [RQ10]
      end
   end
endmodule

// [tb/pin_partner.sv]
// Purpose: outside logic wired to one status pin
// Assumes: the device has released the pin while oe_n is high
// Notes: no pull resistor, so a released pin carries what the far side drives
`timescale 1ns/1ps
// ==========================================
// wire level
module pin_partner (
   input wire pin_out,
   input wire pin_oe_n,
   input wire far_lvl,
   output wire pin_in
);
   // device wins while it drives; the far side only reaches the wire once released
   assign pin_in = pin_oe_n ? far_lvl : pin_out;
endmodule

// [tb/status_pin_checker.sv]
// Purpose: timing relations on the status pin ports
// Assumes: configuration tracked from register writes
// Notes: pin levels lag their cause by one clock
`timescale 1ns/1ps
module status_pin_checker (
   input wire clk,
   input wire rst_n,
   input wire protection_active,
   input wire main_output_on,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire pin2_in,
   input wire pin2_out,
   input wire pin2_oe_n,
   input wire pin3_in,
   input wire pin3_out,
   input wire pin3_oe_n
);
   reg [5:0] c2_r;
   reg [5:0] c3_r;
   reg ok_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // shadow configuration
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c2_r <= 6'h00;
         c3_r <= 6'h00;
         ok_r <= 1'b0;
      end else begin
         ok_r <= 1'b1;
         if (reg_wr && reg_addr == 8'h00)
            c2_r <= reg_wdata[5:0] & 6'h37;
         if (reg_wr && reg_addr == 8'h04)
            c3_r <= reg_wdata[5:0] & 6'h37;
      end
   end
   sequence true_wr;
      (reg_wr && reg_addr == 8'h00 && reg_wdata[5:0] == 6'h02) ##1 !(reg_wr && reg_addr == 8'h00);
   endsequence
   sequence cfg_rd;
      reg_rd && reg_addr == 8'h04;
   endsequence
   // ==========================================
   // assertions
   prot_level_a: assert property (ok_r && $past(c2_r[1:0]) == 2'h0 |->
      pin2_out == (!$past(protection_active) ^ $past(c2_r[2]))) else $error("pin2 status level");
   off_level_a: assert property (ok_r && $past(c3_r[1:0]) == 2'h0 |->
      pin3_out == (!$past(main_output_on) ^ $past(c3_r[2]))) else $error("pin3 status level");
   in_release_a: assert property (ok_r && $past(c2_r[1:0]) == 2'h1 |-> pin2_oe_n)
      else $error("pin2 driven in input function");
   drive_en_a: assert property (ok_r && !$past(c3_r[0]) |-> !pin3_oe_n)
      else $error("pin3 not driven");
   prot_drive_a: assert property (ok_r && !$past(c2_r[0]) |-> !pin2_oe_n)
      else $error("pin2 not driven");
   fixed_out_a: assert property (ok_r && $past(c3_r[1:0]) == 2'h2 &&
      $past(c3_r[5:4]) != 2'h2 |-> pin3_out == ($past(c3_r[4]) ^ $past(c3_r[2])))
      else $error("pin3 fixed level");
   true_drive_a: assert property (true_wr |=> !pin2_out && !pin2_oe_n)
      else $error("pin2 true level");
   cfg_read_a: assert property (cfg_rd |=> reg_rdata == {26'h0, $past(c3_r)})
      else $error("pin3 config readback");
endmodule
bind status_pin_function_select status_pin_checker chk_i (.clk(clk), .rst_n(rst_n),
   .protection_active(protection_active), .main_output_on(main_output_on),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pin2_in(pin2_in), .pin2_out(pin2_out), .pin2_oe_n(pin2_oe_n),
   .pin3_in(pin3_in), .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n));

// [tb/testbench.sv]
// Purpose: random and corner tests of the status pin selector
// Assumes: 200 MHz clock, reads answer one cycle later
// Notes: pwm counted over whole periods so phase does not matter
`timescale 1ns/1ps
module testbench;
   reg clk, rst_n, prot, mon, wr, rd, e2, e3, x2, x3;
   reg [7:0] addr;
   reg [31:0] wd, rnd, d;
   reg [5:0] c2, c3;
   wire [31:0] rdata;
   wire p2i, p2o, p2e, p3i, p3o, p3e;
   integer mismatches, compares, i, n2, n3;
   status_pin_function_select uut (.clk(clk), .rst_n(rst_n), .protection_active(prot),
      .main_output_on(mon), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .pin2_in(p2i), .pin2_out(p2o), .pin2_oe_n(p2e), .pin3_in(p3i),
      .pin3_out(p3o), .pin3_oe_n(p3e));
   pin_partner far2 (.pin_out(p2o), .pin_oe_n(p2e), .far_lvl(e2), .pin_in(p2i));
   pin_partner far3 (.pin_out(p3o), .pin_oe_n(p3e), .far_lvl(e3), .pin_in(p3i));
   always #2.5 clk = ~clk;
   // ==========================================
   // helpers
   function [31:0] xs(input [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // status or fixed output level; true selection is the low level
   function exp_out(input [5:0] c, input st);
      exp_out = (c[1] ? c[4] : st) ^ c[2];
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wreg(input [7:0] a, input [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task final_report;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // sequence
   initial begin
      #20000;
      mismatches = mismatches + 1;
      final_report;
   end
   initial begin
      {clk, rst_n, prot, mon, wr, rd, e2, e3} = 8'h01;
      addr = 8'h00;
      wd = 32'h0;
      rnd = 32'h3F;
      mismatches = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(8'h00);
      chk(d, 32'h0);
      rreg(8'h04);
      chk(d, 32'h0);
      chk({p3o, p2o}, 2'h3);
      wreg(8'h00, 32'h2);
      repeat (2) @(posedge clk);
      #1 chk(p2o, 1'b0);
      for (i = 0; i < 40; i = i + 1) begin
         rnd = xs(rnd);
         c2 = {1'b0, rnd[0], 1'b0, rnd[1], rnd[3:2] % 2'h3};
         c3 = {1'b0, rnd[4], 1'b0, rnd[5], rnd[7:6] % 2'h3};
         wreg(8'h00, {26'h0, c2});
         wreg(8'h04, {26'h0, c3});
         @(posedge clk);
         {prot, mon, e2, e3} <= rnd[11:8];
         repeat (2) @(posedge clk);
         #1 chk({p3e, p2e}, {c3[1:0] == 2'h1, c2[1:0] == 2'h1});
         if (c2[1:0] != 2'h1)
            chk(p2o, exp_out(c2, !prot));
         if (c3[1:0] != 2'h1)
            chk(p3o, exp_out(c3, !mon));
         // a released pin is driven low behind its enable
         x2 = c2[0] ? 1'b0 : exp_out(c2, !prot);
         x3 = c3[0] ? 1'b0 : exp_out(c3, !mon);
         rreg(8'h18);
         chk(d[1:0], {(c3[0] ? e3 : p3o) ^ c3[2], (c2[0] ? e2 : p2o) ^ c2[2]});
         chk(d[3:2], {x3, x2});
      end
      wreg(8'h00, 32'hFFFFFFFF);
      wreg(8'h04, 32'h32);
      rreg(8'h00);
      chk(d, 32'h37);
      // code 3 releases the pin like the input function; select 3 acts as false
      chk({p3e, p3o, p2e, p2o}, 4'h6);
      wreg(8'h08, 32'h5);
      wreg(8'h0C, 32'h2);
      wreg(8'h10, 32'h4);
      wreg(8'h14, 32'h3);
      wreg(8'h00, 32'h22);
      wreg(8'h04, 32'h26);
      rreg(8'h08);
      chk(d, 32'h5);
      rreg(8'h14);
      chk(d, 32'h3);
      @(posedge clk);
      #1 chk(rdata, 32'h0);
      repeat (4) @(posedge clk);
      n2 = 0;
      n3 = 0;
      repeat (20) begin
         @(posedge clk);
         #1 n2 = n2 + p2o;
         n3 = n3 + p3o;
      end
      chk(n2, 8);
      chk(n3, 5);
      // a zero period parks the waveform low
      wreg(8'h08, 32'h0);
      repeat (2) @(posedge clk);
      n2 = 0;
      repeat (10) begin
         @(posedge clk);
         #1 n2 = n2 + p2o;
      end
      chk(n2, 0);
      rreg(8'h1C);
      chk(d, 32'h0);
      final_report;
   end
endmodule
